// >>> hdl/agt_defines.svh
`ifndef AGT_DEFINES_SVH
`define AGT_DEFINES_SVH
// ***********************************************
// register map (byte addresses)
// ***********************************************
`define AGT_REG_STATUS   5'h00
`define AGT_REG_COMMAND  5'h04
`define AGT_REG_HUB_BASE 5'h08
`define AGT_REG_HUB_LIM  5'h0c
`define AGT_REG_COUNT    5'h10
// ***********************************************
// fields and reset values
// ***********************************************
`define AGT_STAT_RATE    3'h7
`define AGT_STAT_FW_CAP  4
`define AGT_CMD_RATE_LO  0
`define AGT_CMD_FW_EN    4
`define AGT_CMD_PORT_EN  8
`define AGT_CMD_RST      32'h0000_0001
`define AGT_HUB_BASE_RST 32'hfe00_0000
`define AGT_HUB_LIM_RST  32'hfeff_ffff
`define AGT_LFSR_SEED    32'h1357_9bdf
// ***********************************************
// port command codes
// ***********************************************
`define AGT_C_RD         4'h0
`define AGT_C_RD_HI      4'h1
`define AGT_C_WR         4'h4
`define AGT_C_WR_HI      4'h5
`define AGT_C_LRD        4'h8
`define AGT_C_LRD_HI     4'h9
`define AGT_C_FLUSH      4'ha
`define AGT_C_FENCE      4'hc
`define AGT_F_MRD        4'h6
`define AGT_F_MWR        4'h7
`define AGT_F_MRM        4'hc
`define AGT_F_MRL        4'he
`define AGT_F_MWI        4'hf
// bytes per common clock at 1x, 2x, 4x; a block is four clocks
`define AGT_BEAT_1X      5'h04
`define AGT_BEAT_2X      5'h08
`define AGT_BEAT_4X      5'h10
`define AGT_BLOCK_CLKS   3'h4
`endif

// >>> hdl/agt_pkg.sv
package agt_pkg;
    typedef enum logic [2:0] {
        AGT_RATE_1X = 3'b001,
        AGT_RATE_2X = 3'b010,
        AGT_RATE_4X = 3'b100
    } agt_rate_e;
    // request captured from the port pins
    typedef struct packed {
        logic [3:0]  cmd;
        logic        sba;
        logic        frame;
        logic [31:0] addr;
    } agt_lreq_s;
    // request handed to the memory queue
    typedef struct packed {
        logic        fence;
        logic        write;
        logic        hi_prio;
        logic        snoop;
        logic        be_off;
        logic        long_rd;
        logic [31:0] addr;
    } agt_mreq_s;
endpackage

// >>> hdl/agt_target.sv
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "agt_defines.svh"
// Behaviour
// - reads 0000/1000 low, 0001/1001 high priority
// - writes 0100 low, 0101 high priority
// - port cycles only reach main memory
// - hub-range read returns random data
// - hub-range write: memory, byte enables off
// - flush returns one random quadword
// - fence: no data, marker queued
// - pipelined/sideband unsnooped, frame snooped
// - only frame memory writes from hub
// - frame interleaves with pipelined or sideband
// - requests kept in arrival order
// - status advertises 4x in bit 2
// - rate bit 2 selects 4x transfers
// - 4x: 16 bytes/clock, 4-clock blocks
// - 4x strobes extra, same handshake
// - fast writes at 2x and 4x
// - no back-to-back cycles at 1x
// - fast writes need enable bit 4
// - fast write needs capability and enable
// - rate bits pick 4x, 2x, or 1x
module agt_target (
    input  wire logic               ref_clk_in,
    input  wire logic               rstn_in,
    input  wire logic [4:0]         avs_address_in,
    input  wire logic               avs_read_in,
    input  wire logic               avs_write_in,
    input  wire logic [31:0]        avs_writedata_in,
    input  wire logic [3:0]         avs_byteenable_in,
    output logic [31:0]             avs_readdata_out,
    output logic                    avs_waitrequest_out,
    input  wire logic               lk_clk_in,
    input  wire logic               lk_req_in,
    input  wire agt_pkg::agt_lreq_s lk_lreq_in,
    input  wire logic               wr_req_in,
    input  wire logic               wr_hub_in,
    input  wire logic               wr_frame_mem_in,
    output logic                    mem_valid_out,
    output agt_pkg::agt_mreq_s      mem_req_out,
    output logic                    cpl_valid_out,
    output logic                    cpl_flush_out,
    output logic [63:0]             cpl_data_out,
    output logic                    gp_wr_valid_out,
    output agt_pkg::agt_rate_e      gp_wr_rate_out,
    output logic                    back_to_back_cycles_out,
    output agt_pkg::agt_rate_e      xfer_rate_out,
    output logic [4:0]              beat_bytes_out,
    output logic [2:0]              block_clks_out
);
    import agt_pkg::*;

    // ***********************************************
    // pin synchronisers
    // ***********************************************
    // the link clock is only a data pin here; its edges are found on ref_clk_in
    logic [39:0] sync1;
    logic [39:0] sync2;
    logic        clk_old;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1   <= '0;
            sync2   <= '0;
            clk_old <= 1'b0;
        end else begin
            sync1   <= {lk_clk_in, lk_req_in, lk_lreq_in};
            sync2   <= sync1;
            clk_old <= sync2[39];
        end
    end

    // pins are held across the link edge, so sampling after two stages is safe
    logic      lk_edge;
    logic      lk_req;
    agt_lreq_s lreq;

    assign lk_edge = sync2[39] & ~clk_old;
    assign lk_req  = sync2[38];
    assign lreq    = agt_lreq_s'(sync2[37:0]);

    // ***********************************************
    // registers and bus slave
    // ***********************************************
    logic [31:0] cmd_reg;
    logic [31:0] hub_base;
    logic [31:0] hub_lim;
    // counters wrap silently; they are a rough gauge, not an exact log
    logic [15:0] fence_cnt;
    logic [15:0] drop_cnt;
    logic [31:0] next_cmd_reg;
    logic [31:0] next_hub_base;
    logic [31:0] next_hub_lim;
    logic [31:0] next_rdata;
    logic        next_wait;
    logic [31:0] status_val;

    // capability: all rates plus fast write
    assign status_val = {27'h0, 1'b1, 1'b0, `AGT_STAT_RATE};

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic bus_go;
    logic bus_wr_done;

    // a request is answered in the cycle after it is first seen
    assign bus_go = (avs_read_in | avs_write_in) & avs_waitrequest_out;
    // a write lands only at the edge where the master sees waitrequest low
    assign bus_wr_done = avs_write_in & ~avs_waitrequest_out;

    always_comb begin
        next_cmd_reg  = cmd_reg;
        next_hub_base = hub_base;
        next_hub_lim  = hub_lim;
        next_rdata    = avs_readdata_out;
        next_wait     = ~bus_go;
        // writes to read-only or unmapped offsets are answered but change nothing
        if (bus_wr_done) begin
            unique case (avs_address_in)
                `AGT_REG_COMMAND: begin
                    next_cmd_reg = merge(cmd_reg, avs_writedata_in, avs_byteenable_in);
                end
                `AGT_REG_HUB_BASE: begin
                    next_hub_base = merge(hub_base, avs_writedata_in, avs_byteenable_in);
                end
                `AGT_REG_HUB_LIM: begin
                    next_hub_lim = merge(hub_lim, avs_writedata_in, avs_byteenable_in);
                end
                default: begin
                    next_cmd_reg = cmd_reg;
                end
            endcase
        end
        if (bus_go && avs_read_in) begin
            unique case (avs_address_in)
                `AGT_REG_STATUS:   next_rdata = status_val;
                `AGT_REG_COMMAND:  next_rdata = cmd_reg;
                `AGT_REG_HUB_BASE: next_rdata = hub_base;
                `AGT_REG_HUB_LIM:  next_rdata = hub_lim;
                `AGT_REG_COUNT:    next_rdata = {drop_cnt, fence_cnt};
                default:           next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_reg             <= `AGT_CMD_RST;
            hub_base            <= `AGT_HUB_BASE_RST;
            hub_lim             <= `AGT_HUB_LIM_RST;
            avs_readdata_out    <= 32'h0;
            avs_waitrequest_out <= 1'b1;
        end else begin
            cmd_reg             <= next_cmd_reg;
            hub_base            <= next_hub_base;
            hub_lim             <= next_hub_lim;
            avs_readdata_out    <= next_rdata;
            avs_waitrequest_out <= next_wait;
        end
    end

    // ***********************************************
    // rate and fast write selection
    // ***********************************************
    logic [2:0] rate_bits;
    logic       fw_en;
    logic       port_en;
    agt_rate_e  next_xfer;
    agt_rate_e  next_fw;
    logic [4:0] next_beat;

    assign rate_bits = cmd_reg[`AGT_CMD_RATE_LO +: 3];
    assign fw_en     = cmd_reg[`AGT_CMD_FW_EN] & status_val[`AGT_STAT_FW_CAP];
    assign port_en   = cmd_reg[`AGT_CMD_PORT_EN];

    // the rate is taken live from the register; software sets it once after
    // reset, so no handshake with the transfer logic is needed
    // a non one-hot setting is illegal; it falls back to 1x
    always_comb begin
        next_xfer = AGT_RATE_1X;
        next_beat = `AGT_BEAT_1X;
        if (rate_bits == 3'b100) begin
            next_xfer = AGT_RATE_4X;
            next_beat = `AGT_BEAT_4X;
        end else if (rate_bits == 3'b010) begin
            next_xfer = AGT_RATE_2X;
            next_beat = `AGT_BEAT_2X;
        end
        next_fw = AGT_RATE_1X;
        if (fw_en && rate_bits != 3'b001) begin
            next_fw = next_xfer;
        end
    end

    // ***********************************************
    // request decode toward memory
    // ***********************************************
    logic        in_hub;
    logic        next_mem_valid;
    agt_mreq_s   next_mem_req;
    logic        next_cpl_valid;
    logic        next_cpl_flush;
    logic [15:0] next_fence_cnt;
    logic [15:0] next_drop_cnt;
    logic [31:0] lfsr;
    logic [31:0] next_lfsr;

    // limit is inclusive, so a window may end at the very top of the map
    assign in_hub = (lreq.addr >= hub_base) && (lreq.addr <= hub_lim);

    always_comb begin
        next_mem_valid = 1'b0;
        next_mem_req   = mem_req_out;
        next_cpl_valid = 1'b0;
        next_cpl_flush = 1'b0;
        next_fence_cnt = fence_cnt;
        next_drop_cnt  = drop_cnt;
        // completion data need only be arbitrary; a free-running lfsr costs no memory read
        next_lfsr      = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        // one request per link edge, issued in arrival order
        if (lk_edge && lk_req && port_en) begin
            next_mem_req         = '0;
            next_mem_req.addr    = lreq.addr;
            next_mem_req.snoop   = lreq.frame;
            // frame cycles aimed at the hub window are simply not claimed
            if (lreq.frame) begin
                unique case (lreq.cmd)
                    `AGT_F_MRD, `AGT_F_MRM, `AGT_F_MRL: begin
                        next_mem_valid = ~in_hub;
                    end
                    `AGT_F_MWR, `AGT_F_MWI: begin
                        next_mem_valid     = ~in_hub;
                        next_mem_req.write = 1'b1;
                    end
                    default: begin
                        next_drop_cnt = drop_cnt + 16'h1;
                    end
                endcase
            end else begin
                unique case (lreq.cmd)
                    // hub-range reads never leave; the completion path answers them
                    `AGT_C_RD, `AGT_C_RD_HI, `AGT_C_LRD, `AGT_C_LRD_HI: begin
                        next_mem_req.hi_prio = lreq.cmd[0];
                        next_mem_req.long_rd = lreq.cmd[3];
                        next_mem_valid       = ~in_hub;
                        next_cpl_valid       = in_hub;
                    end
                    `AGT_C_WR, `AGT_C_WR_HI: begin
                        next_mem_req.write   = 1'b1;
                        next_mem_req.hi_prio = lreq.cmd[0];
                        next_mem_req.be_off  = in_hub;
                        next_mem_valid       = 1'b1;
                    end
                    `AGT_C_FLUSH: begin
                        next_cpl_valid = 1'b1;
                        next_cpl_flush = 1'b1;
                    end
                    // a fence carries no data; only its place in the queue matters
                    `AGT_C_FENCE: begin
                        next_mem_req.fence = 1'b1;
                        next_mem_valid     = 1'b1;
                        next_fence_cnt     = fence_cnt + 16'h1;
                    end
                    default: begin
                        next_drop_cnt = drop_cnt + 16'h1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_valid_out <= 1'b0;
            mem_req_out   <= '0;
            cpl_valid_out <= 1'b0;
            cpl_flush_out <= 1'b0;
            cpl_data_out  <= 64'h0;
            fence_cnt     <= 16'h0;
            drop_cnt      <= 16'h0;
            lfsr          <= `AGT_LFSR_SEED;
        end else begin
            mem_valid_out <= next_mem_valid;
            mem_req_out   <= next_mem_req;
            cpl_valid_out <= next_cpl_valid;
            cpl_flush_out <= next_cpl_flush;
            cpl_data_out  <= {lfsr, next_lfsr};
            fence_cnt     <= next_fence_cnt;
            drop_cnt      <= next_drop_cnt;
            lfsr          <= next_lfsr;
        end
    end

    // ***********************************************
    // writes toward the graphics master
    // ***********************************************
    logic      next_gp_valid;
    agt_rate_e next_gp_rate;
    logic      next_b2b;

    // hub may only send frame memory writes; anything else is not forwarded
    // back-to-back cycles follow the fast write rate, never plain 1x
    always_comb begin
        next_gp_valid = wr_req_in & (~wr_hub_in | wr_frame_mem_in);
        next_gp_rate  = next_fw;
        next_b2b      = (next_fw != AGT_RATE_1X);
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gp_wr_valid_out         <= 1'b0;
            gp_wr_rate_out          <= AGT_RATE_1X;
            back_to_back_cycles_out <= 1'b0;
            xfer_rate_out           <= AGT_RATE_1X;
            beat_bytes_out          <= `AGT_BEAT_1X;
            block_clks_out          <= `AGT_BLOCK_CLKS;
        end else begin
            gp_wr_valid_out         <= next_gp_valid;
            gp_wr_rate_out          <= next_gp_rate;
            back_to_back_cycles_out <= next_b2b;
            xfer_rate_out           <= next_xfer;
            beat_bytes_out          <= next_beat;
            block_clks_out          <= `AGT_BLOCK_CLKS;
        end
    end

endmodule

// >>> test/agt_target_chk.sv
`timescale 1ns/1ps
// ****
// port checks, bound into the target
// ****
module agt_target_chk
    import agt_pkg::*;
(
    input wire logic      ref_clk_in,
    input wire logic      rstn_in,
    input wire logic      avs_read_in,
    input wire logic      avs_write_in,
    input wire logic      avs_waitrequest_out,
    input wire logic      wr_req_in,
    input wire logic      wr_hub_in,
    input wire logic      wr_frame_mem_in,
    input wire logic      gp_wr_valid_out,
    input wire agt_rate_e gp_wr_rate_out,
    input wire logic      back_to_back_cycles_out,
    input wire agt_rate_e xfer_rate_out,
    input wire logic [4:0] beat_bytes_out,
    input wire logic [2:0] block_clks_out,
    input wire logic      cpl_valid_out,
    input wire logic      cpl_flush_out,
    input wire logic      mem_valid_out,
    input wire agt_mreq_s mem_req_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_bus_taken;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_wr_ok;
        wr_req_in && (!wr_hub_in || wr_frame_mem_in);
    endsequence
    a_bus_answer: assert property (s_bus_taken |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not one cycle");
    a_wr_forward: assert property (s_wr_ok |=> gp_wr_valid_out)
        else $error("write to master lost");
    a_hub_drop: assert property (wr_req_in && wr_hub_in && !wr_frame_mem_in |=> !gp_wr_valid_out)
        else $error("unsupported hub write sent");
    a_b2b_rate: assert property (back_to_back_cycles_out == (gp_wr_rate_out != AGT_RATE_1X))
        else $error("back to back at wrong rate");
    a_fast_rate: assert property (gp_wr_rate_out != AGT_RATE_1X |-> gp_wr_rate_out == xfer_rate_out)
        else $error("fast write rate differs");
    a_beat_rate: assert property (beat_bytes_out == ((xfer_rate_out == AGT_RATE_4X) ? 5'h10 :
        (xfer_rate_out == AGT_RATE_2X) ? 5'h08 : 5'h04))
        else $error("beat size wrong for rate");
    a_block_four: assert property (block_clks_out == 3'h4)
        else $error("block length not four");
    a_flush_cpl: assert property (cpl_flush_out |-> cpl_valid_out)
        else $error("flush without completion");
    a_fence_quiet: assert property (mem_valid_out && mem_req_out.fence |-> !cpl_valid_out ##1 !cpl_valid_out)
        else $error("fence returned data");
    a_one_pulse: assert property (mem_valid_out |=> !mem_valid_out)
        else $error("memory request repeated");
endmodule
bind agt_target agt_target_chk u_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out), .wr_req_in(wr_req_in), .wr_hub_in(wr_hub_in),
    .wr_frame_mem_in(wr_frame_mem_in), .gp_wr_valid_out(gp_wr_valid_out),
    .gp_wr_rate_out(gp_wr_rate_out), .back_to_back_cycles_out(back_to_back_cycles_out),
    .xfer_rate_out(xfer_rate_out), .beat_bytes_out(beat_bytes_out),
    .block_clks_out(block_clks_out), .cpl_valid_out(cpl_valid_out),
    .cpl_flush_out(cpl_flush_out), .mem_valid_out(mem_valid_out), .mem_req_out(mem_req_out));

// >>> test/agt_gfx_master.sv
`timescale 1ns/1ps
// ****
// graphics master: one request per link edge
// ****
module agt_gfx_master (
    output logic               lk_clk_out,
    output logic               lk_req_out,
    output agt_pkg::agt_lreq_s lk_lreq_out
);
    import agt_pkg::*;
    initial begin
        lk_clk_out = 1'b0;
        lk_req_out = 1'b0;
        lk_lreq_out = '0;
    end
    // link clock stands still between requests, so a free-running edge detect is caught
    task automatic send(input logic [3:0] c, input logic s, input logic f, input logic [31:0] a);
        lk_lreq_out <= '{cmd: c, sba: s, frame: f, addr: a};
        lk_req_out <= 1'b1;
        #40 lk_clk_out <= 1'b1;
        #40 lk_clk_out <= 1'b0;
        lk_req_out <= 1'b0;
        // released lines flip so a late capture shows up
        lk_lreq_out <= ~lk_lreq_out;
    endtask
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
    import agt_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [4:0] addr = '0;
    logic rd = 1'b0, wr = 1'b0, wr_req = 1'b0, wr_hub = 1'b0, wr_fm = 1'b0;
    logic [31:0] wdat = '0, rdat, q;
    logic wreq, mem_valid, cpl_valid, cpl_flush, gp_valid, b2b, lk_clk, lk_req;
    agt_lreq_s lk_lreq;
    agt_mreq_s mem_req, m;
    agt_rate_e gp_rate, xfer;
    logic [4:0] beat;
    logic [3:0] be = 4'hf;
    logic [63:0] cdat;
    logic [3:0] nm = '0, nc = '0, nf = '0;
    logic [31:0] rv [6] = '{32'h17, 32'h1, 32'hfe00_0000, 32'hfeff_ffff, 32'h0, 32'h0};
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    agt_target dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .lk_clk_in(lk_clk),
        .lk_req_in(lk_req), .lk_lreq_in(lk_lreq), .wr_req_in(wr_req), .wr_hub_in(wr_hub),
        .wr_frame_mem_in(wr_fm), .mem_valid_out(mem_valid), .mem_req_out(mem_req),
        .cpl_valid_out(cpl_valid), .cpl_flush_out(cpl_flush), .cpl_data_out(cdat),
        .gp_wr_valid_out(gp_valid), .gp_wr_rate_out(gp_rate), .back_to_back_cycles_out(b2b),
        .xfer_rate_out(xfer), .beat_bytes_out(beat), .block_clks_out());
    agt_gfx_master gm (.lk_clk_out(lk_clk), .lk_req_out(lk_req), .lk_lreq_out(lk_lreq));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdat <= d;
        @(posedge ref_clk_in);
        while (wreq !== 1'b0) @(posedge ref_clk_in);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic do_reset;
        rstn_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        chk(cdat, 64'h0);
        rstn_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
    endtask
    function automatic logic [1:0] kind(input logic [3:0] c, input logic f, input logic h);
        if (f) return (!h && c inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf}) ? 2'h1 : 2'h0;
        case (c)
            4'h0, 4'h1, 4'h8, 4'h9: return h ? 2'h2 : 2'h1;
            4'h4, 4'h5, 4'hc: return 2'h1;
            4'ha: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction
    // i packs frame in bit 0, command in 4:1, hub range in bit 5
    task automatic lk(input int i, input logic [1:0] k);
        logic [3:0] c;
        logic f;
        logic h;
        logic [31:0] a;
        c = i[4:1];
        f = i[0];
        h = i[5];
        a = h ? 32'hfe00_0040 : 32'h0010_0000 + 32'(i) * 32'h40;
        nm = '0;
        nc = '0;
        nf = '0;
        gm.send(c, i[1] & !f, f, a);
        repeat (8) @(posedge ref_clk_in);
        chk({nm, nc, nf}, {3'h0, k == 2'h1, 3'h0, k[1], 3'h0, k == 2'h3});
        if (k == 2'h1 && c == 4'hc && !f) chk(m.fence, 1'b1);
        else if (k == 2'h1) chk({m.fence, m.write, m.snoop, m.be_off, m.hi_prio & !f, m.long_rd & !f, m.addr},
            {1'b0, f ? (c == 4'h7 || c == 4'hf) : c[2], f, !f & c[2] & h, !f & c[0], !f & c[3], a});
    endtask
    always @(posedge ref_clk_in) begin
        cyc++;
        if (mem_valid === 1'b1) begin
            nm++;
            m = mem_req;
        end
        if (cpl_valid === 1'b1) nc++;
        if (cpl_flush === 1'b1) nf++;
        if (cyc == 20000) begin
            errors++;
            close_out;
        end
    end
    initial begin
        logic [2:0] rt;
        logic [2:0] gp;
        logic fw;
        // rate is fixed after start, so each setting gets its own reset
        for (int r = 0; r < 4; r++) begin
            rt = (r == 0) ? 3'h4 : 3'h1 << (r - 1);
            fw = (r != 0);
            gp = (fw && !rt[0]) ? rt : 3'h1;
            do_reset;
            bus(1'b1, 5'h04, {23'h0, 1'b1, 3'h0, fw, 1'b0, rt});
            bus(1'b0, 5'h04, '0);
            chk({q[8], q[4], q[2:0]}, {1'b1, fw, rt});
            chk({xfer, beat, gp_rate, b2b}, {rt, rt[2] ? 5'h10 : rt[1] ? 5'h08 : 5'h04, gp, gp != 3'h1});
            for (int j = 0; j < 3; j++) begin
                @(posedge ref_clk_in);
                wr_req <= 1'b1;
                wr_hub <= (j != 0);
                wr_fm <= (j == 2);
                @(posedge ref_clk_in);
                wr_req <= 1'b0;
                @(posedge ref_clk_in);
                chk(gp_valid, j != 1);
            end
        end
        do_reset;
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, 5'(k * 4), '0);
            chk(q, rv[k]);
        end
        bus(1'b1, 5'h00, '0);
        bus(1'b0, 5'h00, '0);
        chk(q, 32'h17);
        be <= 4'h1;
        bus(1'b1, 5'h0c, 32'h1234_5678);
        be <= 4'hf;
        bus(1'b0, 5'h0c, '0);
        chk(q, 32'hfeff_ff78);
        lk(0, 2'h0);
        bus(1'b1, 5'h04, 32'h104);
        for (int i = 0; i < 64; i++) lk(i, kind(i[4:1], i[0], i[5]));
        bus(1'b0, 5'h10, '0);
        chk(q, {16'h26, 16'h2});
        close_out;
    end
endmodule
